/* ctt_params.svh */
// constants of the continuous transmission test block
`ifndef CTT_PARAMS_SVH
`define CTT_PARAMS_SVH
// register offsets
`define CTT_OFF_STATUS     6'h01
`define CTT_OFF_CMD        6'h02
`define CTT_OFF_PHY_MODE   6'h0a
`define CTT_OFF_RAW_SEL    6'h0c
`define CTT_OFF_IRQ_MASK   6'h0e
`define CTT_OFF_IRQ_STAT   6'h0f
`define CTT_OFF_SYN_CAL    6'h1a
`define CTT_OFF_KEY        6'h1c
`define CTT_OFF_TEST       6'h36
`define CTT_OFF_FB_PTR     6'h3e
`define CTT_OFF_FB_DATA    6'h3f
// reset values
`define CTT_RST_PHY_MODE   8'h37
`define CTT_RST_RAW_SEL    8'h20
`define CTT_RST_SYN_CAL    8'h57
`define CTT_RST_KEY        8'h0a
`define CTT_RST_ZERO       8'h00
// values that carry meaning
`define CTT_SEL_ON         4'hf
`define CTT_KEY_FIRST      8'h54
`define CTT_KEY_SECOND     8'h46
`define CTT_KEY_OFF        8'h00
`define CTT_RAW_CW         8'h03
`define CTT_MODE_CW        8'h37
`define CTT_CMD_TX_START   8'h02
`define CTT_CMD_OFF        8'h03
`define CTT_CMD_PLL_ON     8'h09
`define CTT_CODE_BUSY_TX   8'h02
`define CTT_CODE_OFF       8'h08
`define CTT_CODE_PLL_ON    8'h09
`define CTT_BYTE_LOW       8'h00
`define CTT_BYTE_HIGH      8'hff
// field positions
`define CTT_SEL_MSB        3
`define CTT_IRQ_LOCK       0
`define CTT_IRQ_WRAP       1
`define CTT_LEN_MSB        6
`define CTT_PSDU_FIRST     7'h01
`define CTT_LAST_BIT       3'h7
`endif

/* ctt_pkg.sv */
// types of the continuous transmission test block
package ctt_pkg;
  typedef enum logic [2:0] {
    CTT_TRX_IDLE = 3'b001,
    CTT_TRX_PLL  = 3'b010,
    CTT_TRX_BUSY = 3'b100
  } ctt_trx_t;
  typedef enum logic [2:0] {
    CTT_KEY_NONE  = 3'b001,
    CTT_KEY_HALF  = 3'b010,
    CTT_KEY_ARMED = 3'b100
  } ctt_key_t;
  typedef enum logic [3:0] {
    CTT_TX_IDLE  = 4'b0001,
    CTT_TX_FETCH = 4'b0010,
    CTT_TX_LOAD  = 4'b0100,
    CTT_TX_SHIFT = 4'b1000
  } ctt_tx_t;
  typedef struct packed {
    logic on;
    logic bit_out;
    logic tone_upper;
    logic tone_lower;
  } ctt_air_t;
endpackage : ctt_pkg

/* ctt_frame_mem.sv */
// frame buffer memory, one write port and one registered read port
`timescale 1ns/10ps
module ctt_frame_mem #(
  parameter int AW = 7,
  parameter int DW = 8
) (
  input  wire logic          mclk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [AW-1:0] raddr,
  output      logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // no reset on the array; read data come from a register
  always_ff @(posedge mclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule : ctt_frame_mem

/* ctt_top.sv */
// continuous transmission test mode logic of the transceiver
//
// Summary of operation
// R1: while test mode is active, loaded frame or carrier is sent without pause
// R2: carrier mode sends tone half a megahertz above or below centre, never at it
// R3: sync header and PHY header are skipped; PSDU bytes repeat endlessly
// R4: host loads the buffer with at least a valid PHY header first
// R5: host preferably loads a 127-byte frame for pseudo-random mode
// R6: test select field bits 3:0; 0xf enables, 0x0 off, others reserved
// R7: enable by 0x0f to test register, then 0x54, 0x46 to key; 0x00 disables
// R8: carrier mode only: 0x03 to raw select, 0x37 to phy mode register
// R9: host commands pll on, then the transmit start command
// R10: host unmasks only pll lock; device reports lock through that source
// R11: after reset host clears auto checksum and commands idle off state
// R12: host sets master clock output during setup
// R13: host may pick the channel, optional
// R14: host may pick output power, optional
// R15: after lock is reported, transmit start enters busy transmit and output
// R16: carrier bytes all 0x00 give lower tone, all 0xff give upper tone
// R17: host preferably loads random maximum-length payload for mask tests
// R18: slow lock: host flips lsb of synth filter calibration and waits
// R19: test field resets to zero; output needs both key writes accepted
//
// The strobed register port is this design's own decision.
`timescale 1ns/10ps
`include "ctt_params.svh"
module ctt_top
  import ctt_pkg::*;
#(
  parameter int AW = 7
) (
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic [5:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output      logic [7:0] reg_rdata,
  input  wire logic       pll_lock,
  input  wire logic       tx_bit_clk,
  output      logic       pll_enable,
  output      logic [7:0] synth_filter_calibration,
  output      ctt_air_t   air,
  output      logic       irq
);
  // register hit decode, shared by every write and the read mux
  function automatic logic hit(input logic [5:0] a, input logic [5:0] off);
    return a == off;
  endfunction : hit

  logic [3:0]    test_mode_select;
  logic [7:0]    key_reg;
  logic [7:0]    raw_sel;
  logic [7:0]    phy_mode;
  logic [7:0]    irq_mask;
  logic [1:0]    irq_stat;
  logic [AW-1:0] fb_ptr;
  logic [AW-1:0] psdu_len;
  ctt_trx_t      trx;
  ctt_key_t      key_st;
  ctt_tx_t       tx_st;
  logic [AW-1:0] byte_idx;
  logic [2:0]    bit_cnt;
  logic [7:0]    shreg;
  logic [7:0]    mem_rdata;
  logic [2:0]    sy [2];
  logic [1:0]    flt;
  logic [1:0]    flt_d;
  logic          test_active;
  logic          cw_mode;
  logic          fb_we;
  logic          lock_rise;
  logic          link_edge;
  logic          wrap_evt;

  // inputs from outside: three stages, a change counts once stages 2 and 3 agree
  for (genvar g = 0; g < 2; g++) begin : g_sync
    always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
        sy[g]  <= 3'h0;
        flt[g] <= 1'b0;
        flt_d[g] <= 1'b0;
      end else begin
        sy[g] <= {sy[g][1:0], (g == 0) ? pll_lock : tx_bit_clk};
        if (sy[g][1] == sy[g][2]) begin
          flt[g] <= sy[g][2];
        end
        flt_d[g] <= flt[g];
      end
    end
  end

  assign lock_rise = flt[0] & ~flt_d[0];
  assign link_edge = flt[1] & ~flt_d[1];

  // the output engine runs only when the field and both keys agree
  assign test_active = (test_mode_select == `CTT_SEL_ON) && (key_st == CTT_KEY_ARMED); // R6 R19
  assign cw_mode     = (raw_sel == `CTT_RAW_CW) && (phy_mode == `CTT_MODE_CW);
  assign fb_we       = reg_wr && hit(reg_addr, `CTT_OFF_FB_DATA);

  // plain configuration registers
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      test_mode_select         <= 4'h0; // R19
      raw_sel                  <= `CTT_RST_RAW_SEL;
      phy_mode                 <= `CTT_RST_PHY_MODE;
      irq_mask                 <= `CTT_RST_ZERO;
      synth_filter_calibration <= `CTT_RST_SYN_CAL;
    end else if (reg_wr) begin
      if (hit(reg_addr, `CTT_OFF_TEST)) begin
        test_mode_select <= reg_wdata[`CTT_SEL_MSB:0]; // R6
      end
      if (hit(reg_addr, `CTT_OFF_RAW_SEL)) begin
        raw_sel <= reg_wdata;
      end
      if (hit(reg_addr, `CTT_OFF_PHY_MODE)) begin
        phy_mode <= reg_wdata;
      end
      if (hit(reg_addr, `CTT_OFF_IRQ_MASK)) begin
        irq_mask <= reg_wdata; // R10
      end
      // whole byte stored so software can flip the lsb and keep the rest
      if (hit(reg_addr, `CTT_OFF_SYN_CAL)) begin
        synth_filter_calibration <= reg_wdata;
      end
    end
  end

  // key register: 0x54 then 0x46 arms, 0x00 disarms; other values restart before arming and are ignored once armed
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      key_reg <= `CTT_RST_KEY;
      key_st  <= CTT_KEY_NONE;
    end else if (reg_wr && hit(reg_addr, `CTT_OFF_KEY)) begin
      key_reg <= reg_wdata;
      unique case (key_st)
        CTT_KEY_NONE: begin
          key_st <= (reg_wdata == `CTT_KEY_FIRST) ? CTT_KEY_HALF : CTT_KEY_NONE; // R7
        end
        CTT_KEY_HALF: begin
          if (reg_wdata == `CTT_KEY_SECOND) begin
            key_st <= CTT_KEY_ARMED; // R7
          end else if (reg_wdata == `CTT_KEY_FIRST) begin
            key_st <= CTT_KEY_HALF;
          end else begin
            key_st <= CTT_KEY_NONE;
          end
        end
        CTT_KEY_ARMED: begin
          if (reg_wdata == `CTT_KEY_OFF) begin
            key_st <= CTT_KEY_NONE; // R7
          end
        end
      endcase
    end
  end

  // frame buffer pointer auto-increments; a write at index 0 is the length byte
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      fb_ptr   <= '0;
      psdu_len <= '0;
    end else if (reg_wr && hit(reg_addr, `CTT_OFF_FB_PTR)) begin
      fb_ptr <= reg_wdata[AW-1:0];
    end else if (fb_we) begin
      fb_ptr <= fb_ptr + 1'b1;
      if (fb_ptr == '0) begin
        psdu_len <= reg_wdata[`CTT_LEN_MSB:0];
      end
    end
  end

  ctt_frame_mem #(.AW(AW), .DW(8)) u_mem (
    .mclk  (mclk),
    .we    (fb_we),
    .waddr (fb_ptr),
    .wdata (reg_wdata),
    .raddr (byte_idx),
    .rdata (mem_rdata)
  );

  // transceiver state: off, pll on, busy transmit
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      trx        <= CTT_TRX_IDLE;
      pll_enable <= 1'b0;
    end else begin
      if (reg_wr && hit(reg_addr, `CTT_OFF_CMD)) begin
        if (reg_wdata == `CTT_CMD_OFF) begin
          trx <= CTT_TRX_IDLE;
        end else if (reg_wdata == `CTT_CMD_PLL_ON && trx == CTT_TRX_IDLE) begin
          trx <= CTT_TRX_PLL;
        end else if (reg_wdata == `CTT_CMD_TX_START && trx == CTT_TRX_PLL
                     && flt[0] && test_active) begin
          trx <= CTT_TRX_BUSY; // R15
        end
      end else if (trx == CTT_TRX_BUSY && !test_active) begin
        trx <= CTT_TRX_PLL; // leaving the test mode stops the output
      end
      pll_enable <= (trx != CTT_TRX_IDLE);
    end
  end

  // output engine: fetch byte, load, shift lsb first on each rising link clock edge
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tx_st    <= CTT_TX_IDLE;
      byte_idx <= '0;
      bit_cnt  <= 3'h0;
      shreg    <= 8'h00;
      wrap_evt <= 1'b0;
    end else begin
      wrap_evt <= 1'b0;
      if (trx != CTT_TRX_BUSY) begin
        tx_st    <= CTT_TX_IDLE;
        byte_idx <= `CTT_PSDU_FIRST; // R3
      end else begin
        unique case (tx_st)
          CTT_TX_IDLE: begin
            tx_st <= CTT_TX_FETCH;
          end
          CTT_TX_FETCH: begin
            tx_st <= CTT_TX_LOAD;
          end
          CTT_TX_LOAD: begin
            shreg   <= mem_rdata;
            bit_cnt <= 3'h0;
            tx_st   <= CTT_TX_SHIFT;
          end
          CTT_TX_SHIFT: begin
            if (link_edge) begin
              shreg   <= {1'b0, shreg[7:1]};
              bit_cnt <= bit_cnt + 1'b1;
              if (bit_cnt == `CTT_LAST_BIT) begin
                tx_st <= CTT_TX_FETCH;
                // a zero length still repeats byte 1 rather than stalling
                if (byte_idx >= psdu_len) begin
                  byte_idx <= `CTT_PSDU_FIRST; // R1 R3
                  wrap_evt <= 1'b1;
                end else begin
                  byte_idx <= byte_idx + 1'b1;
                end
              end
            end
          end
        endcase
      end
    end
  end

  // air output; the carrier tone follows the byte and never sits on centre
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      air <= '0;
    end else begin
      air.on <= (trx == CTT_TRX_BUSY); // R1
      if (tx_st == CTT_TX_SHIFT && link_edge) begin
        air.bit_out    <= cw_mode ? 1'b0 : shreg[0];
        air.tone_upper <= cw_mode && (shreg == `CTT_BYTE_HIGH ||
                          (bit_cnt != 3'h0 && air.tone_upper)); // R16
        air.tone_lower <= cw_mode && !(shreg == `CTT_BYTE_HIGH ||
                          (bit_cnt != 3'h0 && air.tone_upper)); // R2 R16
      end else if (trx != CTT_TRX_BUSY) begin
        air.bit_out    <= 1'b0;
        air.tone_upper <= 1'b0;
        air.tone_lower <= 1'b0;
      end
    end
  end

  // sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      irq_stat <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (reg_wr && hit(reg_addr, `CTT_OFF_IRQ_STAT) && reg_wdata[i]) begin
          irq_stat[i] <= 1'b0;
        end
      end
      if (lock_rise) begin
        irq_stat[`CTT_IRQ_LOCK] <= 1'b1; // R10
      end
      if (wrap_evt) begin
        irq_stat[`CTT_IRQ_WRAP] <= 1'b1;
      end
    end
  end

  // level interrupt from any unmasked status bit
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat & irq_mask[1:0]); // R10
    end
  end

  // read data stand one cycle after the strobe, zero otherwise
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (!reg_rd) begin
      reg_rdata <= 8'h00;
    end else begin
      unique case (1'b1)
        hit(reg_addr, `CTT_OFF_STATUS): begin
          reg_rdata <= (trx == CTT_TRX_BUSY) ? `CTT_CODE_BUSY_TX :
                       (trx == CTT_TRX_PLL)  ? `CTT_CODE_PLL_ON : `CTT_CODE_OFF;
        end
        hit(reg_addr, `CTT_OFF_TEST):      reg_rdata <= {4'h0, test_mode_select};
        hit(reg_addr, `CTT_OFF_KEY):       reg_rdata <= key_reg;
        hit(reg_addr, `CTT_OFF_RAW_SEL):   reg_rdata <= raw_sel;
        hit(reg_addr, `CTT_OFF_PHY_MODE):  reg_rdata <= phy_mode;
        hit(reg_addr, `CTT_OFF_IRQ_MASK):  reg_rdata <= irq_mask;
        hit(reg_addr, `CTT_OFF_IRQ_STAT):  reg_rdata <= {6'h00, irq_stat};
        hit(reg_addr, `CTT_OFF_SYN_CAL):   reg_rdata <= synth_filter_calibration;
        hit(reg_addr, `CTT_OFF_FB_PTR):    reg_rdata <= {1'b0, fb_ptr};
        default:                           reg_rdata <= 8'h00;
      endcase
    end
  end
endmodule : ctt_top

/* ctt_top_sva.sv */
// assertion checker of the continuous transmission test block
`timescale 1ns/10ps
`include "ctt_params.svh"
module ctt_top_sva
  import ctt_pkg::*;
(
  input wire logic       mclk,
  input wire logic       nrst,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       pll_lock,
  input wire logic       tx_bit_clk,
  input wire logic       pll_enable,
  input wire logic [7:0] synth_filter_calibration,
  input wire ctt_air_t   air,
  input wire logic       irq
);
  logic [7:0] mask_sh;
  logic [7:0] test_sh;
  logic       half;
  logic       armed;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  // shadows of mask and test field, seen only through bus writes
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst) mask_sh <= 8'h00;
    else if (reg_wr && reg_addr == `CTT_OFF_IRQ_MASK) mask_sh <= reg_wdata;
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst) test_sh <= 8'h00;
    else if (reg_wr && reg_addr == `CTT_OFF_TEST) test_sh <= reg_wdata;
  // key tracker; a repeated first key keeps the half state
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst) {half, armed} <= 2'b00;
    else if (reg_wr && reg_addr == `CTT_OFF_KEY)
      {half, armed} <= {reg_wdata == `CTT_KEY_FIRST, half && reg_wdata == `CTT_KEY_SECOND};
  a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero");
  a_test_readback: assert property ($past(reg_rd) && $past(reg_addr) == `CTT_OFF_TEST
    |-> reg_rdata[3:0] == test_sh[3:0]) else $error("test field readback");
  a_tone_excl: assert property (!(air.tone_upper && air.tone_lower))
    else $error("both tones");
  a_tone_idle: assert property (!air.on && !$past(air.on) |-> !air.tone_upper && !air.tone_lower)
    else $error("tone while off");
  a_on_pll: assert property (air.on |-> pll_enable) else $error("on without pll");
  a_on_keyed: assert property ($rose(air.on) |-> armed && test_sh[3:0] == `CTT_SEL_ON)
    else $error("output without keys");
  a_key_off: assert property (reg_wr && reg_addr == `CTT_OFF_KEY && reg_wdata == 8'h00
    |-> ##[1:3] !air.on) else $error("disarm ignored");
  a_tx_start: assert property (reg_wr && reg_addr == `CTT_OFF_CMD && reg_wdata == 8'h02
    && pll_enable && !air.on && pll_lock && $past(pll_lock, 6) && armed
    && test_sh[3:0] == `CTT_SEL_ON |-> ##[1:3] air.on) else $error("start ignored");
  a_cal_copy: assert property (reg_wr && reg_addr == `CTT_OFF_SYN_CAL
    |=> synth_filter_calibration == $past(reg_wdata)) else $error("cal not copied");
  a_irq_mask: assert property (irq |-> ($past(mask_sh) & 8'h03) != 8'h00)
    else $error("irq while masked");
  a_lock_irq: assert property (mask_sh[0] && $rose(pll_lock) |-> ##[3:7] irq)
    else $error("lock not reported");
endmodule : ctt_top_sva
bind ctt_top ctt_top_sva u_sva (
  .mclk                     (mclk),
  .nrst                     (nrst),
  .reg_addr                 (reg_addr),
  .reg_wdata                (reg_wdata),
  .reg_wr                   (reg_wr),
  .reg_rd                   (reg_rd),
  .reg_rdata                (reg_rdata),
  .pll_lock                 (pll_lock),
  .tx_bit_clk               (tx_bit_clk),
  .pll_enable               (pll_enable),
  .synth_filter_calibration (synth_filter_calibration),
  .air                      (air),
  .irq                      (irq)
);

/* ctt_synth_model.sv */
// synthesizer and bit clock model at the radio side of the block
`timescale 1ns/10ps
module ctt_synth_model
  import ctt_pkg::*;
#(
  parameter int LOCK_DLY = 20
) (
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic       pll_enable,
  input  wire logic [7:0] synth_filter_calibration,
  input  wire ctt_air_t   air,
  input  wire logic       slow,
  output      logic       pll_lock,
  output      logic       tx_bit_clk
);
  int cnt;
  // lock age; a slow part only locks once the filter lsb reads zero
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst) cnt <= 0;
    else if (!pll_enable || (slow && synth_filter_calibration[0])) cnt <= 0;
    else if (cnt < LOCK_DLY) cnt <= cnt + 1;
  assign pll_lock = (cnt == LOCK_DLY);
  // bit clock stands still while the output is off; offset from mclk
  initial begin
    tx_bit_clk = 1'b0;
    #13;
    forever begin
      #200;
      tx_bit_clk = air.on ? ~tx_bit_clk : 1'b0;
    end
  end
endmodule : ctt_synth_model

/* ctt_top_tb.sv */
// self-checking bench of the continuous transmission test block
`timescale 1ns/10ps
`include "ctt_params.svh"
module ctt_top_tb
  import ctt_pkg::*;
;
  logic        mclk      = 1'b0;
  logic        nrst      = 1'b0;
  logic [5:0]  reg_addr  = 6'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic        slow      = 1'b0;
  logic [7:0]  reg_rdata;
  logic [7:0]  synth_filter_calibration;
  logic        pll_lock;
  logic        tx_bit_clk;
  logic        pll_enable;
  logic        irq;
  ctt_air_t    air;
  logic [47:0] bits;
  int          miscompares = 0;
  int          check_count = 0;

  always #25 mclk = ~mclk;

  ctt_top #(.AW(7)) DUT (
    .mclk                     (mclk),
    .nrst                     (nrst),
    .reg_addr                 (reg_addr),
    .reg_wdata                (reg_wdata),
    .reg_wr                   (reg_wr),
    .reg_rd                   (reg_rd),
    .reg_rdata                (reg_rdata),
    .pll_lock                 (pll_lock),
    .tx_bit_clk               (tx_bit_clk),
    .pll_enable               (pll_enable),
    .synth_filter_calibration (synth_filter_calibration),
    .air                      (air),
    .irq                      (irq)
  );
  ctt_synth_model #(.LOCK_DLY(20)) u_synth (
    .mclk                     (mclk),
    .nrst                     (nrst),
    .pll_enable               (pll_enable),
    .synth_filter_calibration (synth_filter_calibration),
    .air                      (air),
    .slow                     (slow),
    .pll_lock                 (pll_lock),
    .tx_bit_clk               (tx_bit_clk)
  );

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // one-cycle strobes with a quiet cycle after, so no signal is set twice in a step
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [7:0] e, input string n);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(n, e, reg_rdata);
    @(posedge mclk);
  endtask : rd

  task automatic load(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2);
    wr(`CTT_OFF_FB_PTR, 8'h00);
    wr(`CTT_OFF_FB_DATA, b0);
    wr(`CTT_OFF_FB_DATA, b1);
    wr(`CTT_OFF_FB_DATA, b2);
  endtask : load

  task automatic arm();
    wr(`CTT_OFF_KEY, `CTT_KEY_FIRST);
    wr(`CTT_OFF_KEY, `CTT_KEY_SECOND);
    wr(`CTT_OFF_CMD, `CTT_CMD_TX_START);
  endtask : arm

  // bounded wait for the interrupt level, sampled off the launching edge
  task automatic wait_irq(input int lim, input logic e);
    int k;
    k = 0;
    while (k < lim && irq !== e) begin
      @(negedge mclk);
      k++;
    end
    chk("irq", e, irq);
    @(posedge mclk);
  endtask : wait_irq

  // bit n is sampled a full bit period after its edge; find two whole copies
  task automatic grab(input logic [15:0] pat);
    logic hit;
    hit = 1'b0;
    repeat (48) begin
      @(posedge tx_bit_clk);
      bits = {air.bit_out, bits[47:1]};
    end
    for (int j = 0; j < 16; j++) begin
      if (bits[j +: 16] === pat && bits[j + 16 +: 16] === pat) hit = 1'b1;
    end
    chk("stream", 8'h01, hit);
    @(posedge mclk);
  endtask : grab

  task automatic tones(input logic up);
    int u;
    int l;
    u = 0;
    l = 0;
    repeat (400) begin
      @(negedge mclk);
      u += air.tone_upper;
      l += air.tone_lower;
    end
    chk("upper", up, u > 0);
    chk("lower", !up, l > 0);
    @(posedge mclk);
  endtask : tones

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test

  // whole run is near 10000 cycles, mostly the long frame; allow several times that
  initial begin
    #2000000;
    miscompares++;
    finish_test();
  end

  initial begin
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    rd(`CTT_OFF_TEST, `CTT_RST_ZERO, "test");
    rd(`CTT_OFF_KEY, `CTT_RST_KEY, "key");
    rd(`CTT_OFF_SYN_CAL, `CTT_RST_SYN_CAL, "cal");
    $display("reset test done");
    wr(`CTT_OFF_IRQ_MASK, 8'h01);
    wr(6'h04, 8'h00);
    wr(`CTT_OFF_CMD, `CTT_CMD_OFF);
    wr(6'h03, 8'h01);
    wr(6'h08, 8'h33);
    wr(6'h05, 8'h00);
    rd(6'h08, 8'h00, "unmapped");
    rd(`CTT_OFF_STATUS, `CTT_CODE_OFF, "state");
    wr(`CTT_OFF_TEST, 8'h0f);
    rd(`CTT_OFF_TEST, 8'h0f, "test");
    load(8'h02, 8'ha5, 8'h3c);
    rd(`CTT_OFF_FB_PTR, 8'h03, "ptr");
    wr(`CTT_OFF_CMD, `CTT_CMD_PLL_ON);
    wait_irq(100, 1'b1);
    rd(`CTT_OFF_IRQ_STAT, 8'h01, "status");
    wr(`CTT_OFF_CMD, `CTT_CMD_TX_START);
    rd(`CTT_OFF_STATUS, `CTT_CODE_PLL_ON, "state");
    arm();
    rd(`CTT_OFF_STATUS, `CTT_CODE_BUSY_TX, "state");
    grab(16'h3ca5);
    rd(`CTT_OFF_IRQ_STAT, 8'h03, "status");
    wr(`CTT_OFF_KEY, `CTT_KEY_OFF);
    rd(`CTT_OFF_STATUS, `CTT_CODE_PLL_ON, "state");
    $display("stream test done");
    // full-length frame: the wrap flag may only rise once all 127 bytes are out
    wr(`CTT_OFF_FB_PTR, 8'h00);
    wr(`CTT_OFF_FB_DATA, 8'h7f);
    for (int i = 1; i < 128; i++) begin
      wr(`CTT_OFF_FB_DATA, 8'(i * 37));
    end
    wr(`CTT_OFF_IRQ_STAT, 8'h02);
    arm();
    repeat (4000) @(posedge mclk);
    rd(`CTT_OFF_IRQ_STAT, 8'h01, "status");
    repeat (4500) @(posedge mclk);
    rd(`CTT_OFF_IRQ_STAT, 8'h03, "status");
    wr(`CTT_OFF_KEY, `CTT_KEY_OFF);
    $display("long frame test done");
    wr(`CTT_OFF_RAW_SEL, `CTT_RAW_CW);
    wr(`CTT_OFF_PHY_MODE, `CTT_MODE_CW);
    rd(`CTT_OFF_RAW_SEL, `CTT_RAW_CW, "raw");
    rd(`CTT_OFF_PHY_MODE, `CTT_MODE_CW, "phy");
    for (int i = 0; i < 2; i++) begin
      load(8'h01, i ? 8'h00 : 8'hff, 8'h00);
      arm();
      tones(i == 0);
      wr(`CTT_OFF_KEY, `CTT_KEY_OFF);
    end
    $display("carrier test done");
    wr(`CTT_OFF_CMD, `CTT_CMD_OFF);
    slow <= 1'b1;
    wr(`CTT_OFF_IRQ_STAT, 8'h03);
    wait_irq(5, 1'b0);
    wr(`CTT_OFF_CMD, `CTT_CMD_PLL_ON);
    repeat (100) @(negedge mclk);
    chk("irq", 8'h00, irq);
    @(posedge mclk);
    rd(`CTT_OFF_SYN_CAL, `CTT_RST_SYN_CAL, "cal");
    wr(`CTT_OFF_SYN_CAL, `CTT_RST_SYN_CAL ^ 8'h01);
    chk("cal", `CTT_RST_SYN_CAL ^ 8'h01, synth_filter_calibration);
    wait_irq(100, 1'b1);
    wr(`CTT_OFF_IRQ_MASK, 8'h00);
    wait_irq(5, 1'b0);
    $display("lock test done");
    // closing device reset must clear the test field and the state again
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    rd(`CTT_OFF_TEST, `CTT_RST_ZERO, "test");
    rd(`CTT_OFF_STATUS, `CTT_CODE_OFF, "state");
    $display("second reset test done");
    finish_test();
  end
endmodule : ctt_top_tb
